// ===== hw/wdc_clear.v
/*
  Watchdog counter with its clearing logic, status flags and an
  AHB-Lite slave for the control and status registers.
  Assumes a free-running low-frequency time base on lf_base_pin
  (about 32 ticks per millisecond), asynchronous to hclk, and a core
  that signals Sleep, clear instructions, oscillator events and its
  own synchronous device reset as single-clock levels or pulses.
*/
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "wdc_defs.vh"

module wdc_clear
(
  // Bus clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Low-frequency time base pin
  input  wire        lf_base_pin,
  // Core events
  input  wire        device_reset,
  input  wire        watchdog_clear_instruction,
  input  wire        sleep_active,
  input  wire        osc_fail,
  input  wire        oscillator_startup_timer,
  // Watchdog results
  output reg         wdt_reset_req,
  output reg         wdt_wake_req,
  output wire        timeout_status_flag,
  output wire        powerdown_status_flag,
  output wire        watchdog_reset_cause_flag
);

  // Control and status storage
  reg                   software_watchdog_enable_r;
  reg [`WDC_PS_W-1:0]   timeout_period_select_r;
  reg                   to_flag_r;
  reg                   pd_flag_r;
  reg                   cause_flag_r;
  reg [`WDC_CNT_W-1:0]  count_r;
  reg [`WDC_CNT_W-1:0]  count_nxt;
  reg                   sleep_d_r;

  // Time base synchroniser
  reg                   lf_s1_r;
  reg                   lf_s2_r;
  reg                   lf_s3_r;
  reg                   lf_level_r;

  // Bus data-phase capture
  reg                   dp_write_r;
  reg [7:0]             dp_addr_r;

  wire       bus_take;
  wire       wr_ctrl;
  wire       wr_stat;
  wire       lf_tick;
  wire       sleep_edge;
  wire       hold_clear;
  wire       timeout;
  wire [`WDC_CNT_W-1:0] limit;
  wire                  ctrl_en_now;
  wire [`WDC_PS_W-1:0]  ctrl_ps_now;

  // Control reset word as a sized constant, so its period field can be sliced
  localparam [7:0] CTRL_RST_WORD = `WDC_CONTROL_RST;

  // Ticks in the selected period, capped at the longest code
  function [`WDC_CNT_W-1:0] period_ticks;
    input [`WDC_PS_W-1:0] code;
    reg   [`WDC_PS_W-1:0] c;
    begin
      c = (code > `WDC_PS_MAX) ? `WDC_PS_MAX : code;
      period_ticks = `WDC_BASE_TICKS << c; // RL1
    end
  endfunction

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign bus_take  = hsel & hready & (htrans == `WDC_HTRANS_NONSEQ);
  assign wr_ctrl   = dp_write_r & (dp_addr_r == `WDC_OFS_CONTROL);
  assign wr_stat   = dp_write_r & (dp_addr_r == `WDC_OFS_STATUS);

  // Control value as it will stand after this edge; a pipelined read
  // right behind a control write must not return the old contents
  assign ctrl_en_now = device_reset ? 1'b0 :
                       wr_ctrl      ? hwdata[`WDC_EN_BIT] :
                                      software_watchdog_enable_r;
  assign ctrl_ps_now = device_reset ? CTRL_RST_WORD[`WDC_PS_MSB:`WDC_PS_LSB] :
                       wr_ctrl      ? hwdata[`WDC_PS_MSB:`WDC_PS_LSB] :
                                      timeout_period_select_r;

  assign timeout_status_flag       = to_flag_r;
  assign powerdown_status_flag     = pd_flag_r;
  assign watchdog_reset_cause_flag = cause_flag_r;

  // Address phase capture; zero-wait slave, reads are prepared early
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write_r <= 1'b0;
      dp_addr_r  <= 8'h00;
      hrdata     <= 32'h00000000;
    end
    else
    begin
      dp_write_r <= bus_take & hwrite;
      dp_addr_r  <= haddr;
      if (bus_take & ~hwrite)
      begin
        case (haddr)
          `WDC_OFS_CONTROL:
            hrdata <= {26'h0000000, ctrl_ps_now, ctrl_en_now};
          `WDC_OFS_STATUS:
            hrdata <= {29'h00000000, cause_flag_r, pd_flag_r, to_flag_r};
          default:
            hrdata <= 32'h00000000; // Unmapped reads as zero
        endcase
      end
    end
  end

  // Control register; the core's device reset restores the default too
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      software_watchdog_enable_r <= 1'b0;
      timeout_period_select_r    <= CTRL_RST_WORD[`WDC_PS_MSB:`WDC_PS_LSB]; // RL2
    end
    else if (device_reset)
    begin
      software_watchdog_enable_r <= 1'b0;
      timeout_period_select_r    <= CTRL_RST_WORD[`WDC_PS_MSB:`WDC_PS_LSB]; // RL2
    end
    else if (wr_ctrl)
    begin
      software_watchdog_enable_r <= hwdata[`WDC_EN_BIT];
      timeout_period_select_r    <= hwdata[`WDC_PS_MSB:`WDC_PS_LSB];
    end
  end

  // Three-stage synchroniser; a level counts once stages two and three agree
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lf_s1_r    <= 1'b0;
      lf_s2_r    <= 1'b0;
      lf_s3_r    <= 1'b0;
      lf_level_r <= 1'b0;
    end
    else
    begin
      lf_s1_r <= lf_base_pin;
      lf_s2_r <= lf_s1_r;
      lf_s3_r <= lf_s2_r;
      if (lf_s2_r == lf_s3_r)
        lf_level_r <= lf_s3_r;
    end
  end

  // Counting off a separate base keeps the core divider out of the count
  assign lf_tick = (lf_s2_r == lf_s3_r) & lf_s3_r & ~lf_level_r; // RL9

  // Sleep entry and exit both show as a change of the sleep level
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sleep_d_r <= 1'b0;
    else
      sleep_d_r <= sleep_active;
  end

  assign sleep_edge = sleep_active ^ sleep_d_r; // RL5

  // Every reason the counter must sit at zero this cycle
  assign hold_clear = device_reset                      // RL3
                    | osc_fail                          // RL3
                    | ~software_watchdog_enable_r       // RL3
                    | watchdog_clear_instruction        // RL4
                    | sleep_edge                        // RL5
                    | oscillator_startup_timer;         // RL6 RL8

  assign limit   = period_ticks(timeout_period_select_r);
  assign timeout = ~hold_clear & lf_tick & (count_r == limit - 24'h000001);

  // Counter next value
  always @*
  begin
    count_nxt = count_r;
    if (hold_clear)
      count_nxt = {`WDC_CNT_W{1'b0}};
    else if (timeout)
      count_nxt = {`WDC_CNT_W{1'b0}};
    else if (lf_tick)
      count_nxt = count_r + 24'h000001;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count_r <= {`WDC_CNT_W{1'b0}}; // RL3
    else
      count_r <= count_nxt;
  end

  // Time-out outcome: wake in Sleep, device reset when awake
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wdt_reset_req <= 1'b0;
      wdt_wake_req  <= 1'b0;
    end
    else
    begin
      wdt_wake_req  <= timeout & sleep_active;  // RL7
      wdt_reset_req <= timeout & ~sleep_active; // RL10
    end
  end

  // Status flags; a set in the clearing cycle wins over the clear
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      to_flag_r    <= 1'b0;
      pd_flag_r    <= 1'b0;
      cause_flag_r <= 1'b0;
    end
    else
    begin
      if (timeout)
        to_flag_r <= 1'b1; // RL7
      else if (watchdog_clear_instruction)
        to_flag_r <= 1'b0;
      if (timeout & sleep_active)
        pd_flag_r <= 1'b1; // RL7
      else if (watchdog_clear_instruction)
        pd_flag_r <= 1'b0;
      // Cause survives the device reset it produced; write one to clear
      if (timeout & ~sleep_active)
        cause_flag_r <= 1'b1; // RL10
      else if (wr_stat & hwdata[`WDC_ST_RSTCAUSE])
        cause_flag_r <= 1'b0;
    end
  end

endmodule

// ===== hw/wdc_defs.vh
/*
  Constants for the watchdog clear logic: register offsets, field
  positions, reset values and time base figures.
  Assumes the including file is a design module clocked by hclk.
*/
// What this block does
// RL1: Period select field sets time-out, 1 ms-256 s.
// RL2: Any reset loads period select for two seconds.
// RL3: Reset, oscillator failure, disable clear the counter.
// RL4: Clear instruction zeroes count; software must repeat.
// RL5: Sleep entry and Sleep exit clear the counter.
// RL6: Counter held clear while start-up timer runs.
// RL7: Time-out in Sleep wakes, sets status flags.
// RL8: Crystal clock Sleep exit: clear until start-up ends.
// RL9: Oscillator divider change leaves count unaffected.
// RL10: Awake enabled time-out resets device, records cause.
`ifndef WDC_DEFS_VH
`define WDC_DEFS_VH

// Register byte offsets
`define WDC_OFS_CONTROL     8'h00
`define WDC_OFS_STATUS      8'h04

// Control register fields
`define WDC_EN_BIT          0
`define WDC_PS_LSB          1
`define WDC_PS_MSB          5
`define WDC_PS_W            5
`define WDC_CONTROL_RST     8'h16

// Status register fields
`define WDC_ST_TIMEOUT      0
`define WDC_ST_POWERDOWN    1
`define WDC_ST_RSTCAUSE     2

// Period code 0 is 1 ms: 32 ticks of the low-frequency base
`define WDC_BASE_TICKS      24'h000020
`define WDC_PS_MAX          5'h12
`define WDC_CNT_W           24

// AHB transfer type
`define WDC_HTRANS_NONSEQ   2'h2

`endif

// ===== verification/tb_top.sv
/*
  Self-checking bench for wdc_clear: registers, time-outs, clearing events.
  Assumes the checker is bound in and hready follows hreadyout.
*/
`timescale 1ns/1ps
module tb_top;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, lf_base_pin = 1'h0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd, lfsr = 32'h101EC;
  logic        device_reset = 1'h0, watchdog_clear_instruction = 1'h0, sleep_active = 1'h0;
  logic        osc_fail = 1'h0, oscillator_startup_timer = 1'h0, hreadyout, hresp;
  logic        wdt_reset_req, wdt_wake_req, timeout_status_flag;
  logic        powerdown_status_flag, watchdog_reset_cause_flag;
  int          n_fail = 0, tests_run = 0, n_rst = 0, n_wake = 0;

  // The one slave's hreadyout is the bus's hready
  wdc_clear u_wdc_clear
  (
    .hclk                       (hclk),
    .hresetn                    (hresetn),
    .hsel                       (hsel),
    .haddr                      (haddr),
    .htrans                     (htrans),
    .hwrite                     (hwrite),
    .hsize                      (hsize),
    .hwdata                     (hwdata),
    .hready                     (hreadyout),
    .hreadyout                  (hreadyout),
    .hresp                      (hresp),
    .hrdata                     (hrdata),
    .lf_base_pin                (lf_base_pin),
    .device_reset               (device_reset),
    .watchdog_clear_instruction (watchdog_clear_instruction),
    .sleep_active               (sleep_active),
    .osc_fail                   (osc_fail),
    .oscillator_startup_timer   (oscillator_startup_timer),
    .wdt_reset_req              (wdt_reset_req),
    .wdt_wake_req               (wdt_wake_req),
    .timeout_status_flag        (timeout_status_flag),
    .powerdown_status_flag      (powerdown_status_flag),
    .watchdog_reset_cause_flag  (watchdog_reset_cause_flag)
  );

  // 50 ns clock
  always #25 hclk = ~hclk;
  // Count request pulses; the pulses last one cycle, so each edge sees one at most
  always @(posedge hclk)
  begin
    if (wdt_reset_req === 1'h1) n_rst++;
    if (wdt_wake_req === 1'h1) n_wake++;
  end

  // Random source and expected control readback
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [31:0] ctl_exp(input [31:0] w);
    ctl_exp = w & 32'h3F;
  endfunction

  task chk(input string nm, input [31:0] exp, input [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One single word transfer; read data lands in rd
  task bus(input [7:0] a, input w, input [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  // Slow time base ticks; the low phase leaves room for the 3-4 cycle sync
  task ticks(input int n);
    repeat (n)
    begin
      lf_base_pin <= 1'h1;
      repeat (4) @(posedge hclk);
      lf_base_pin <= 1'h0;
      repeat (6) @(posedge hclk);
    end
  endtask

  task req(input [31:0] r, input [31:0] w);
    chk("reset requests", r, n_rst);
    chk("wake requests", w, n_wake);
    n_rst = 0;
    n_wake = 0;
  endtask

  // Hold one clearing level across 40 ticks, then count a full period
  task hold(input int s);
    ticks(20);
    if (s == 0) osc_fail <= 1'h1;
    else oscillator_startup_timer <= 1'h1;
    ticks(40);
    osc_fail <= 1'h0;
    oscillator_startup_timer <= 1'h0;
    ticks(31);
    req(0, 0);
    ticks(1);
    req(1, 0);
  endtask

  task end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(8'h00, 1'h0, 32'h0); chk("control", 32'h16, rd);
    bus(8'h08, 1'h1, 32'hFFFFFFFF); bus(8'h08, 1'h0, 32'h0); chk("unmapped", 32'h0, rd);
    repeat (4)
    begin
      lfsr = nx(lfsr);
      bus(8'h00, 1'h1, lfsr); bus(8'h00, 1'h0, 32'h0); chk("control", ctl_exp(lfsr), rd);
    end
    bus(8'h00, 1'h1, 32'h1); ticks(31); req(0, 0); ticks(1); req(1, 0);
    bus(8'h04, 1'h0, 32'h0); chk("status", 32'h5, rd);
    bus(8'h04, 1'h1, 32'h4); bus(8'h04, 1'h0, 32'h0); chk("status", 32'h1, rd);
    lfsr = nx(lfsr);
    ticks(lfsr % 31 + 1);
    watchdog_clear_instruction <= 1'h1;
    @(posedge hclk);
    watchdog_clear_instruction <= 1'h0;
    ticks(31); req(0, 0); bus(8'h04, 1'h0, 32'h0); chk("status", 32'h0, rd);
    ticks(1); req(1, 0);
    hold(0);
    hold(1);
    ticks(20); sleep_active <= 1'h1; ticks(31); req(0, 0); ticks(1); req(0, 1);
    bus(8'h04, 1'h0, 32'h0); chk("powerdown", 32'h3, rd & 32'h3);
    ticks(20); sleep_active <= 1'h0; ticks(31); req(0, 0); ticks(1); req(1, 0);
    bus(8'h00, 1'h1, 32'h0); ticks(40); req(0, 0);
    bus(8'h00, 1'h1, 32'h1); ticks(20);
    device_reset <= 1'h1;
    @(posedge hclk);
    device_reset <= 1'h0;
    ticks(40); req(0, 0); bus(8'h00, 1'h0, 32'h0); chk("control", 32'h16, rd);
    bus(8'h00, 1'h1, 32'h3); ticks(63); req(0, 0); ticks(1); req(1, 0);
    // Mid-run bus reset with a part-count in hand, then a full period again
    bus(8'h00, 1'h1, 32'h1); ticks(20);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(8'h04, 1'h0, 32'h0); chk("status", 32'h0, rd);
    bus(8'h00, 1'h0, 32'h0); chk("control", 32'h16, rd);
    bus(8'h00, 1'h1, 32'h1); ticks(31); req(0, 0); ticks(1); req(1, 0);
    end_sim;
  end

  // Hang guard: about three times the expected run
  initial
  begin
    #1000000;
    n_fail++;
    end_sim;
  end
endmodule

// ===== verification/wdc_checker.sv
/*
  Checker for wdc_clear: request pulses, status flags, clearing events.
  Assumes it is bound to wdc_clear and sees only that module's ports.
*/
`timescale 1ns/1ps
module wdc_chk
(
  // Clock, reset and bus answer
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  // Core events
  input wire logic device_reset,
  input wire logic watchdog_clear_instruction,
  input wire logic sleep_active,
  input wire logic osc_fail,
  input wire logic oscillator_startup_timer,
  // Watchdog results
  input wire logic wdt_reset_req,
  input wire logic wdt_wake_req,
  input wire logic timeout_status_flag,
  input wire logic powerdown_status_flag,
  input wire logic watchdog_reset_cause_flag
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Neither request pulses in this cycle
  sequence s_quiet;
    !wdt_reset_req && !wdt_wake_req;
  endsequence
  // Some time-out request pulses in this cycle
  sequence s_req;
    wdt_reset_req || wdt_wake_req;
  endsequence
  // Zero wait and always OKAY, so the bench never has to retry
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not OKAY");
  a_awake_reset: assert property (wdt_reset_req |-> !$past(sleep_active) &&
    timeout_status_flag && watchdog_reset_cause_flag ##1 s_quiet) else $error("reset req bad");
  a_sleep_wake: assert property (wdt_wake_req |-> $past(sleep_active) && !wdt_reset_req &&
    powerdown_status_flag && timeout_status_flag ##1 s_quiet) else $error("wake req bad");
  a_fail_clear: assert property (osc_fail |=> s_quiet) else $error("req after osc fail");
  a_reset_clear: assert property (device_reset |=> s_quiet) else $error("req after reset");
  a_startup_hold: assert property (oscillator_startup_timer |=> s_quiet)
    else $error("req during start-up");
  a_sleep_edge: assert property ($changed(sleep_active) |=> s_quiet)
    else $error("req after sleep change");
  a_clear_instr: assert property (watchdog_clear_instruction |=> s_quiet [*2])
    else $error("req after clear");
  a_flag_cause: assert property ($rose(timeout_status_flag) |-> s_req)
    else $error("flag rose without time-out");
  a_flag_drop: assert property (watchdog_clear_instruction |=> !powerdown_status_flag ||
    wdt_reset_req || wdt_wake_req) else $error("powerdown flag not cleared");
  a_flag_hold: assert property (timeout_status_flag && !watchdog_clear_instruction |=>
    timeout_status_flag) else $error("timeout flag lost");
endmodule

bind wdc_clear wdc_chk u_wdc_chk
(
  .hclk                       (hclk),
  .hresetn                    (hresetn),
  .hreadyout                  (hreadyout),
  .hresp                      (hresp),
  .device_reset               (device_reset),
  .watchdog_clear_instruction (watchdog_clear_instruction),
  .sleep_active               (sleep_active),
  .osc_fail                   (osc_fail),
  .oscillator_startup_timer   (oscillator_startup_timer),
  .wdt_reset_req              (wdt_reset_req),
  .wdt_wake_req               (wdt_wake_req),
  .timeout_status_flag        (timeout_status_flag),
  .powerdown_status_flag      (powerdown_status_flag),
  .watchdog_reset_cause_flag  (watchdog_reset_cause_flag)
);
